// ---- rtl/sas_defs.vh ----
// register map, field positions and constants of the converter sequencer
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH

// register byte addresses
`define SAS_ADDR_CTRL1 4'h0
`define SAS_ADDR_CTRL2 4'h4
`define SAS_ADDR_CTRL3 4'h8
`define SAS_ADDR_BUF0 4'hc
`define SAS_ADDR_BUF1 5'h10
`define SAS_ADDR_STAT 5'h14
`define SAS_AW 5

// first control register fields
`define SAS_C1_ON 15
`define SAS_C1_IDLE 13
`define SAS_C1_FMT_HI 9
`define SAS_C1_FMT_LO 8
`define SAS_C1_TRG_HI 7
`define SAS_C1_TRG_LO 5
`define SAS_C1_AUTO_SAMPLE_START 2
`define SAS_C1_SAMPLE_ENABLE 1
`define SAS_C1_DONE 0
`define SAS_C1_WMASK 16'ha3e6

// second control register fields
`define SAS_C2_REF_HI 15
`define SAS_C2_REF_LO 13
`define SAS_C2_OFFSET_CALIBRATION 12
`define SAS_C2_SCAN 10
`define SAS_C2_SPI_HI 5
`define SAS_C2_SPI_LO 2
`define SAS_C2_ALT 0
`define SAS_C2_WMASK 16'hf43d

// third control register fields
`define SAS_C3_RC 15
`define SAS_C3_EXT 14
`define SAS_C3_PUMP 13
`define SAS_C3_AUTO_SAMPLE_TIME_HI 12
`define SAS_C3_AUTO_SAMPLE_TIME_LO 8
`define SAS_C3_DIV_HI 5
`define SAS_C3_DIV_LO 0
`define SAS_C3_WMASK 16'hbf3f

// trigger source codes
`define SAS_TRG_MANUAL 3'h0
`define SAS_TRG_PIN 3'h1
`define SAS_TRG_TIMER 3'h2
`define SAS_TRG_AUTO 3'h7

// result formats
`define SAS_FMT_INT 2'h0
`define SAS_FMT_SINT 2'h1
`define SAS_FMT_FRAC 2'h2
`define SAS_FMT_SFRAC 2'h3

// reference codes
`define SAS_REF_EXT_POS 3'h1
`define SAS_REF_EXT_NEG 3'h2
`define SAS_REF_EXT_BOTH 3'h3

// axi responses
`define SAS_RESP_OKAY 2'h0
`define SAS_RESP_SLVERR 2'h2

`endif

// ---- rtl/sas_sequencer.v ----
// converter sequencer: control registers, sample/convert machine, result buffer
// Contract
// - converter_on set runs the module; clear turns it off.
// - idle_stop halts the module during Idle; clear keeps converting.
// - result_format selects integer, signed integer, fraction, signed fraction layout.
// - trigger code 111: internal counter ends sampling after auto-sample time.
// - trigger code 010: timer_one compare match ends sampling.
// - trigger code 001: active edge on external pin ends sampling.
// - trigger code 000: clearing sample_enable ends sampling; 011-110 reserved.
// - auto_sample_start restarts sampling after each conversion, else software sets it.
// - sample_enable reads 1 while acquiring; hardware or software may change it.
// - read-only done sets at conversion end, clears while not finished; under auto_sample_start it stays set through later conversions.
// - buffer contents need not survive converter_on clear; software reads first.
// - reference_select picks references; 1xx acts like 000.
// - offset_calibration ties converter inputs to analog ground.
// - scan_enable scans selected inputs on successive samples.
// - interrupt every sequence for 0000, every second for 0001.
// - alternate_mux_select uses first mux, then alternates second and first.
// - conversion_clock_source selects internal rc clock for conversions.
// - extended_sampling_flag reads 1 while sampling continues after sample_enable clears.
// - charge_pump_enable turns the switch charge pump on or off.
// - auto_sample_time sets auto sampling from 0 to 31 conversion periods.
// - divider gives conversion period of field plus one system cycles.
// - two-word result buffer filled by conversions, read by software.
`timescale 1ns/1ps
`include "sas_defs.vh"
module sas_sequencer #(
   parameter RES_W = 10,
   parameter CONV_TADS = 12
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [`SAS_AW-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [`SAS_AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // device and trigger inputs
   input wire idle_mode,
   input wire timer_one_match,
   input wire external_interrupt_zero_pin,
   input wire rc_clk_in,
   // analog front end
   input wire [RES_W-1:0] sar_result,
   output reg analog_on_r,
   output reg sample_hold_r,
   output reg [2:0] reference_select_r,
   output reg offset_cal_r,
   output reg pump_on_r,
   output reg mux_b_sel_r,
   output reg scan_step_r,
   output reg converter_interrupt_flag_r
);
   localparam ST_IDLE = 2'h0;
   localparam ST_SAMPLE = 2'h1;
   localparam ST_CONV = 2'h2;

   reg [15:0] ctrl1_r;
   reg [15:0] ctrl2_r;
   reg [15:0] ctrl3_r;
   reg [15:0] buf_r [0:1];
   reg [1:0] state_r;
   reg [4:0] sample_enable_cnt_r;
   reg [4:0] conv_cnt_r;
   reg wptr_r;
   reg seq_cnt_r;
   reg alt_r;
   reg done_r;
   reg ext_r;
   reg pin_s1_r;
   reg pin_s2_r;
   reg pin_s3_r;
   reg tmr_s1_r;
   reg tmr_s2_r;
   reg [`SAS_AW-1:0] awaddr_r;
   reg aw_have_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg w_have_r;

   wire on = ctrl1_r[`SAS_C1_ON];
   wire run = on & ~(ctrl1_r[`SAS_C1_IDLE] & idle_mode);
   wire [2:0] trg = ctrl1_r[`SAS_C1_TRG_HI:`SAS_C1_TRG_LO];
   wire [1:0] fmt = ctrl1_r[`SAS_C1_FMT_HI:`SAS_C1_FMT_LO];
   wire [4:0] auto_sample_time = ctrl3_r[`SAS_C3_AUTO_SAMPLE_TIME_HI:`SAS_C3_AUTO_SAMPLE_TIME_LO];
   wire sample_enable = ctrl1_r[`SAS_C1_SAMPLE_ENABLE];
   wire tad_tick;
   wire pin_edge = pin_s2_r & ~pin_s3_r;
   wire wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;

   // end of sampling by selected source
   reg trig_hit;
   always @* begin
      case (trg)
         `SAS_TRG_MANUAL: trig_hit = ~sample_enable;
         `SAS_TRG_PIN: trig_hit = pin_edge;
         `SAS_TRG_TIMER: trig_hit = tmr_s2_r;
         `SAS_TRG_AUTO: trig_hit = tad_tick & (sample_enable_cnt_r >= auto_sample_time);
         default: trig_hit = 1'b0; // reserved codes never trigger
      endcase
   end

   // format the raw result
   reg [15:0] fmt_word;
   always @* begin
      case (fmt)
         `SAS_FMT_INT: fmt_word = {{(16-RES_W){1'b0}}, sar_result};
         `SAS_FMT_SINT: fmt_word = {{(16-RES_W){~sar_result[RES_W-1]}},
            ~sar_result[RES_W-1], sar_result[RES_W-2:0]};
         `SAS_FMT_FRAC: fmt_word = {sar_result, {(16-RES_W){1'b0}}};
         `SAS_FMT_SFRAC: fmt_word = {~sar_result[RES_W-1], sar_result[RES_W-2:0],
            {(16-RES_W){1'b0}}};
         default: fmt_word = 16'h0000;
      endcase
   end

   // byte-lane merge for register writes
   function [15:0] merge;
      input [15:0] old;
      input [15:0] nw;
      input [1:0] be;
      input [15:0] wm;
      begin
         merge = old;
         if (be[0])
            merge[7:0] = (old[7:0] & ~wm[7:0]) | (nw[7:0] & wm[7:0]);
         if (be[1])
            merge[15:8] = (old[15:8] & ~wm[15:8]) | (nw[15:8] & wm[15:8]);
      end
   endfunction

   sas_tad_gen #(
      .DIV_W(6)
   ) u_tad (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(run),
      .use_rc(ctrl3_r[`SAS_C3_RC]),
      .divider(ctrl3_r[`SAS_C3_DIV_HI:`SAS_C3_DIV_LO]),
      .rc_clk_in(rc_clk_in),
      .tick_r(tad_tick)
   );

   // input synchronisers
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
         tmr_s1_r <= 1'b0;
         tmr_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= external_interrupt_zero_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         tmr_s1_r <= timer_one_match;
         tmr_s2_r <= tmr_s1_r;
      end
   end

   // axi write channel capture and response
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= {`SAS_AW{1'b0}};
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SAS_RESP_OKAY;
      end else begin
         // no new write is taken while a response waits for the master
         s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r == {1'b0, `SAS_ADDR_CTRL1} ||
               awaddr_r == {1'b0, `SAS_ADDR_CTRL2} ||
               awaddr_r == {1'b0, `SAS_ADDR_CTRL3}) ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SAS_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SAS_RESP_OKAY;
            case (s_axi_araddr)
               {1'b0, `SAS_ADDR_CTRL1}: s_axi_rdata <= {16'h0000, ctrl1_r[15:1], done_r};
               {1'b0, `SAS_ADDR_CTRL2}: s_axi_rdata <= {16'h0000, ctrl2_r};
               {1'b0, `SAS_ADDR_CTRL3}: s_axi_rdata <= {16'h0000, ctrl3_r[15],
                  ext_r, ctrl3_r[13:0]};
               {1'b0, `SAS_ADDR_BUF0}: s_axi_rdata <= {16'h0000, buf_r[0]};
               `SAS_ADDR_BUF1: s_axi_rdata <= {16'h0000, buf_r[1]};
               `SAS_ADDR_STAT: s_axi_rdata <= {28'h0000000, wptr_r, seq_cnt_r, state_r};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `SAS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // control registers and sequencer
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl1_r <= 16'h0000;
         ctrl2_r <= 16'h0000;
         ctrl3_r <= 16'h0000;
         buf_r[0] <= 16'h0000;
         buf_r[1] <= 16'h0000;
         state_r <= ST_IDLE;
         sample_enable_cnt_r <= 5'h00;
         conv_cnt_r <= 5'h00;
         wptr_r <= 1'b0;
         seq_cnt_r <= 1'b0;
         alt_r <= 1'b0;
         done_r <= 1'b0;
         ext_r <= 1'b0;
         converter_interrupt_flag_r <= 1'b0;
         scan_step_r <= 1'b0;
      end else begin
         converter_interrupt_flag_r <= 1'b0;
         scan_step_r <= 1'b0;
         if (wr_fire && awaddr_r == {1'b0, `SAS_ADDR_CTRL1})
            ctrl1_r <= merge(ctrl1_r, wdata_r[15:0], wstrb_r[1:0], `SAS_C1_WMASK);
         if (wr_fire && awaddr_r == {1'b0, `SAS_ADDR_CTRL2})
            ctrl2_r <= merge(ctrl2_r, wdata_r[15:0], wstrb_r[1:0], `SAS_C2_WMASK);
         if (wr_fire && awaddr_r == {1'b0, `SAS_ADDR_CTRL3})
            ctrl3_r <= merge(ctrl3_r, wdata_r[15:0], wstrb_r[1:0], `SAS_C3_WMASK);
         if (!on) begin
            state_r <= ST_IDLE;
            done_r <= 1'b0;
            ext_r <= 1'b0;
            wptr_r <= 1'b0;
            seq_cnt_r <= 1'b0;
            alt_r <= 1'b0;
            buf_r[0] <= 16'h0000;
            buf_r[1] <= 16'h0000;
         end else if (run) begin
            case (state_r)
               ST_IDLE: begin
                  if (sample_enable) begin
                     state_r <= ST_SAMPLE;
                     sample_enable_cnt_r <= 5'h00;
                     done_r <= 1'b0;
                  end
               end
               ST_SAMPLE: begin
                  if (tad_tick && sample_enable_cnt_r != 5'h1f)
                     sample_enable_cnt_r <= sample_enable_cnt_r + 5'h01;
                  // software drop of sample_enable in other modes keeps sampling
                  ext_r <= ~sample_enable & (trg != `SAS_TRG_MANUAL);
                  if (trig_hit) begin
                     state_r <= ST_CONV;
                     conv_cnt_r <= 5'h00;
                     ext_r <= 1'b0;
                     ctrl1_r[`SAS_C1_SAMPLE_ENABLE] <= 1'b0;
                  end
               end
               ST_CONV: begin
                  if (tad_tick)
                     conv_cnt_r <= conv_cnt_r + 5'h01;
                  if (tad_tick && conv_cnt_r == CONV_TADS - 1) begin
                     buf_r[wptr_r] <= fmt_word;
                     done_r <= 1'b1;
                     alt_r <= ctrl2_r[`SAS_C2_ALT] & ~alt_r;
                     scan_step_r <= ctrl2_r[`SAS_C2_SCAN];
                     if (ctrl2_r[`SAS_C2_SPI_LO] == 1'b0 || seq_cnt_r) begin
                        converter_interrupt_flag_r <= 1'b1;
                        seq_cnt_r <= 1'b0;
                        wptr_r <= 1'b0;
                     end else begin
                        seq_cnt_r <= 1'b1;
                        wptr_r <= ~wptr_r;
                     end
                     state_r <= ST_IDLE;
                     if (ctrl1_r[`SAS_C1_AUTO_SAMPLE_START]) begin
                        ctrl1_r[`SAS_C1_SAMPLE_ENABLE] <= 1'b1;
                        state_r <= ST_SAMPLE;
                        sample_enable_cnt_r <= 5'h00;
                     end
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // analog front-end controls
   always @(posedge aclk) begin
      if (!aresetn) begin
         analog_on_r <= 1'b0;
         sample_hold_r <= 1'b0;
         reference_select_r <= 3'h0;
         offset_cal_r <= 1'b0;
         pump_on_r <= 1'b0;
         mux_b_sel_r <= 1'b0;
      end else begin
         analog_on_r <= run;
         sample_hold_r <= run & (state_r == ST_SAMPLE);
         // 1xx codes fold onto supply references
         reference_select_r <= ctrl2_r[`SAS_C2_REF_HI] ? 3'h0 :
            ctrl2_r[`SAS_C2_REF_HI:`SAS_C2_REF_LO];
         offset_cal_r <= ctrl2_r[`SAS_C2_OFFSET_CALIBRATION];
         pump_on_r <= ctrl3_r[`SAS_C3_PUMP];
         mux_b_sel_r <= alt_r;
      end
   end
endmodule

// ---- rtl/sas_tad_gen.v ----
// conversion clock tick generator: system clock divider or synchronised rc clock
`timescale 1ns/1ps
module sas_tad_gen #(
   parameter DIV_W = 6
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // control
   input wire run,
   input wire use_rc,
   input wire [DIV_W-1:0] divider,
   input wire rc_clk_in,
   // tick out
   output reg tick_r
);
   reg [DIV_W-1:0] cnt_r;
   reg rc_s1_r;
   reg rc_s2_r;
   reg rc_s3_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= {DIV_W{1'b0}};
         rc_s1_r <= 1'b0;
         rc_s2_r <= 1'b0;
         rc_s3_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         rc_s1_r <= rc_clk_in;
         rc_s2_r <= rc_s1_r;
         rc_s3_r <= rc_s2_r;
         if (!run) begin
            cnt_r <= {DIV_W{1'b0}};
            tick_r <= 1'b0;
         end else if (use_rc) begin
            tick_r <= rc_s2_r & ~rc_s3_r;
         end else if (cnt_r >= divider) begin
            cnt_r <= {DIV_W{1'b0}};
            tick_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 1'b1;
            tick_r <= 1'b0;
         end
      end
   end
endmodule

// ---- tb/sas_sequencer_assertions.sv ----
// port-level checks of the converter sequencer
`timescale 1ns/1ps
`include "sas_defs.vh"
module sas_chk #(
   parameter RES_W = 10,
   parameter CONV_TADS = 12
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // register bus
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`SAS_AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // converter side
   input wire sample_hold_r,
   input wire [2:0] reference_select_r,
   input wire converter_interrupt_flag_r
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // a conversion is at least twelve ticks, so eight quiet cycles is safe
   sequence conv_quiet;
      !converter_interrupt_flag_r [*8];
   endsequence
   wr_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   rd_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read answer late");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   unmapped_rd_a: assert property (ar_taken ##0 s_axi_araddr >= 5'h18 |=>
      s_axi_rresp == `SAS_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
   ref_fold_a: assert property (reference_select_r[2] == 1'b0)
      else $error("reference code not folded");
   irq_pulse_a: assert property ($rose(converter_interrupt_flag_r) |=>
      !converter_interrupt_flag_r) else $error("interrupt longer than a pulse");
   conv_len_a: assert property ($fell(sample_hold_r) |-> conv_quiet)
      else $error("conversion too short");
   irq_conv_a: assert property (converter_interrupt_flag_r |->
      !$past(sample_hold_r)) else $error("interrupt while sampling");
endmodule
bind sas_sequencer sas_chk #(.RES_W(RES_W), .CONV_TADS(CONV_TADS)) sas_chk_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_hold_r(sample_hold_r),
   .reference_select_r(reference_select_r),
   .converter_interrupt_flag_r(converter_interrupt_flag_r)
);

// ---- tb/sas_sequencer_tb_top.sv ----
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "sas_defs.vh"
module sas_sequencer_tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic idle_mode, timer_one_match, external_interrupt_zero_pin, rc_clk_in;
   logic [9:0] sar_result;
   logic analog_on_r, sample_hold_r, offset_cal_r, pump_on_r, mux_b_sel_r, scan_step_r;
   logic converter_interrupt_flag_r;
   logic [2:0] reference_select_r, rc_div;
   logic [15:0] rd;
   int err_count, checks, irq_cnt, scan_cnt, n, len, k, j, rdly;
   sas_sequencer sas_sequencer_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .idle_mode(idle_mode), .timer_one_match(timer_one_match),
      .external_interrupt_zero_pin(external_interrupt_zero_pin), .rc_clk_in(rc_clk_in),
      .sar_result(sar_result), .analog_on_r(analog_on_r), .sample_hold_r(sample_hold_r),
      .reference_select_r(reference_select_r), .offset_cal_r(offset_cal_r),
      .pump_on_r(pump_on_r), .mux_b_sel_r(mux_b_sel_r), .scan_step_r(scan_step_r),
      .converter_interrupt_flag_r(converter_interrupt_flag_r)
   );
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // free-running rc oscillator, eight system clocks a period
   always @(posedge aclk) begin
      rc_div <= rc_div + 3'h1;
      rc_clk_in <= rc_div[2];
      if (converter_interrupt_flag_r === 1'b1) irq_cnt <= irq_cnt + 1;
      if (scan_step_r === 1'b1) scan_cnt <= scan_cnt + 1;
   end
   task automatic test_done;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({15'h0, got}, {15'h0, exp});
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {16'h0, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (rdly == 0);
      for (n = 0; n < 64 && !(s_axi_bvalid && s_axi_bready); n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n + 1 == rdly) s_axi_bready <= 1'b1;
      end
      if (n == 64) err_count++;
      s_axi_bready <= 1'b0;
      chk({14'h0, s_axi_bresp}, {14'h0, er});
   endtask
   task automatic rdr(input logic [4:0] a, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (rdly == 0);
      for (n = 0; n < 64 && !(s_axi_rvalid && s_axi_rready); n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (n + 1 == rdly) s_axi_rready <= 1'b1;
      end
      if (n == 64) err_count++;
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata[15:0];
      chk({14'h0, s_axi_rresp}, {14'h0, er});
   endtask
   function automatic logic [15:0] fmt(input logic [1:0] f, input logic [9:0] r);
      logic [9:0] s;
      s = {~r[9], r[8:0]};
      case (f)
         2'h0: fmt = {6'h0, r};
         2'h1: fmt = {{6{s[9]}}, s};
         2'h2: fmt = {r, 6'h0};
         default: fmt = {s, 6'h0};
      endcase
   endfunction
   // one sample/convert sequence ended by trigger source c
   task automatic conv(input logic [2:0] c, input logic [15:0] b, input logic [9:0] r);
      logic [15:0] t;
      t = b | {8'h0, c, 5'h0};
      sar_result <= r;
      wr(`SAS_ADDR_CTRL1, t | 16'h2, 2'h0);
      rdr(`SAS_ADDR_CTRL1, 2'h0);
      chk({14'h0, rd[1:0]}, 16'h2);
      if (c != 3'h2) wr(`SAS_ADDR_CTRL1, t, 2'h0);
      if (c == 3'h1) begin
         rdr(`SAS_ADDR_CTRL3, 2'h0);
         chkb(rd[14], 1'b1);
         external_interrupt_zero_pin <= 1'b1;
      end
      if (c == 3'h2) timer_one_match <= 1'b1;
      rd = 16'h0;
      for (len = 0; len < 40 && rd[0] !== 1'b1; len++) rdr(`SAS_ADDR_CTRL1, 2'h0);
      external_interrupt_zero_pin <= 1'b0;
      timer_one_match <= 1'b0;
      chk({14'h0, rd[1:0]}, 16'h1);
   endtask
   task automatic meas(input logic v);
      for (len = 0; len < 400 && sample_hold_r === v; len++) @(posedge aclk);
   endtask
   task automatic span(input logic v, input int lo, input int hi);
      meas(v);
      chkb(len >= lo && len <= hi, 1'b1);
   endtask
   initial begin
      // a clean run needs under a thousand cycles; this allows 20000
      #1000000;
      err_count++;
      test_done;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, idle_mode, timer_one_match} = '0;
      {external_interrupt_zero_pin, sar_result, rc_div, rc_clk_in} = '0;
      s_axi_wstrb = 4'h3;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 12; i = i + 4) begin
         rdr(i[4:0], 2'h0);
         chk(rd, 16'h0);
      end
      wr(`SAS_ADDR_CTRL2, 16'hffff, 2'h0);
      rdr(`SAS_ADDR_CTRL2, 2'h0);
      chk(rd, 16'hf43d);
      wr(`SAS_ADDR_CTRL3, 16'hffff, 2'h0);
      rdr(`SAS_ADDR_CTRL3, 2'h0);
      chk(rd, 16'hbf3f);
      repeat (3) @(posedge aclk);
      chkb(offset_cal_r, 1'b1);
      chkb(pump_on_r, 1'b1);
      wr(`SAS_ADDR_CTRL3, 16'h0000, 2'h0);
      for (int i = 0; i < 8; i++) begin
         wr(`SAS_ADDR_CTRL2, {i[2:0], 13'h0}, 2'h0);
         repeat (3) @(posedge aclk);
         chk({13'h0, reference_select_r}, {13'h0, i[2] ? 3'h0 : i[2:0]});
      end
      chkb(offset_cal_r, 1'b0);
      chkb(pump_on_r, 1'b0);
      // late ready: responses must stand until taken
      rdly = 4;
      rdr(5'h18, `SAS_RESP_SLVERR);
      chk(rd, 16'h0);
      wr(5'h1c, 16'hffff, `SAS_RESP_SLVERR);
      rdly = 0;
      for (int i = 0; i < 8; i++) begin
         k = irq_cnt;
         conv(3'h0, {6'h20, i[1:0], 8'h0}, i[2] ? 10'h05a : 10'h2a5);
         rdr(`SAS_ADDR_BUF0, 2'h0);
         chk(rd, fmt(i[1:0], i[2] ? 10'h05a : 10'h2a5));
         chk(irq_cnt[15:0], k[15:0] + 16'h1);
      end
      for (int c = 1; c < 3; c++) begin
         conv(c[2:0], 16'h8000, 10'h3c3);
         rdr(`SAS_ADDR_BUF0, 2'h0);
         chk(rd, 16'h03c3);
      end
      wr(`SAS_ADDR_CTRL2, 16'h0405, 2'h0);
      k = irq_cnt;
      j = scan_cnt;
      chkb(mux_b_sel_r, 1'b0);
      conv(3'h0, 16'h8000, 10'h111);
      chkb(mux_b_sel_r, 1'b1);
      chk(irq_cnt[15:0], k[15:0]);
      conv(3'h0, 16'h8000, 10'h222);
      chkb(mux_b_sel_r, 1'b0);
      chk(irq_cnt[15:0], k[15:0] + 16'h1);
      chk(scan_cnt[15:0], j[15:0] + 16'h2);
      rdr(`SAS_ADDR_BUF0, 2'h0);
      chk(rd, 16'h0111);
      rdr(`SAS_ADDR_BUF1, 2'h0);
      chk(rd, 16'h0222);
      wr(`SAS_ADDR_CTRL2, 16'h0000, 2'h0);
      // auto mode: three-tick sampling, two-clock ticks
      wr(`SAS_ADDR_CTRL3, 16'h0301, 2'h0);
      wr(`SAS_ADDR_CTRL1, 16'h80e6, 2'h0);
      meas(1'b1);
      meas(1'b0);
      span(1'b1, 5, 10);
      span(1'b0, 23, 30);
      wr(`SAS_ADDR_CTRL3, 16'h8301, 2'h0);
      meas(1'b1);
      meas(1'b0);
      meas(1'b1);
      span(1'b0, 88, 104);
      idle_mode <= 1'b1;
      repeat (3) @(posedge aclk);
      chkb(analog_on_r, 1'b1);
      wr(`SAS_ADDR_CTRL1, 16'ha0e6, 2'h0);
      repeat (3) @(posedge aclk);
      chkb(analog_on_r, 1'b0);
      idle_mode <= 1'b0;
      repeat (3) @(posedge aclk);
      chkb(analog_on_r, 1'b1);
      wr(`SAS_ADDR_CTRL1, 16'h00e4, 2'h0);
      repeat (3) @(posedge aclk);
      chkb(analog_on_r, 1'b0);
      chkb(sample_hold_r, 1'b0);
      // a closing auto-start may have set sample_enable again
      wr(`SAS_ADDR_CTRL1, 16'h00e4, 2'h0);
      rdr(`SAS_ADDR_CTRL1, 2'h0);
      chk(rd, 16'h00e4);
      rdr(`SAS_ADDR_BUF0, 2'h0);
      chk(rd, 16'h0000);
      test_done;
   end
endmodule
